// file: hdl/ascs_core.sv
// Configuration, status, filter and power-mode logic of the angle sensor.
// Operation
// - Reported angle is raw angle minus a 16-bit zero offset.
// - Zero offset code is a fraction of a full turn in equal steps.
// - Direction bit 0 keeps clockwise positive, 1 makes counterclockwise positive.
// - Bias trim amount is an unsigned 8-bit value from 0 to 255.
// - Trim goes to X and/or Y by enable bits; both means equal reduction.
// - Parity checked on 17-bit writes only; mismatch drops write, sets flag.
// - A write while the store is busy sets the store-collision flag.
// - Restore checks a CRC and flags a mismatch.
// - Error pin is high while any error flag is set.
// - Clear command clears all error flags and drops the error pin.
// - Filter time constant is 2^N us, settling 2^(N+1)-1 us, N capped at 12.
// - Data-valid stays low after entering active mode until settling elapses.
// - Angle on the link lags by the filter time constant plus 3 us.
// - Full-power pin forces active; else selected source picks idle or auto-cycle.
`default_nettype none
`include "ascs_cfg.svh"
module ascs_core
	import ascs_pkg::*;
#(
	parameter int US_CYCLES = `ASCS_CYCLES_PER_US // Core cycles per microsecond tick.
) (
	input wire logic clk_in, // Core clock, 200 MHz.
	input wire logic reset_in, // Asynchronous reset, active high.
	input wire logic sclk_in, // Link clock from the controller.
	input wire logic cs_n_in, // Link chip select, active low.
	input wire logic mosi_in, // Link data in.
	input wire logic full_power_in, // Full-power pin, high forces active mode.
	input wire logic auto_cycle_pin_in, // Auto-cycle control pin.
	input wire logic [15:0] raw_angle_in, // Raw front-end angle, core clock domain.
	input wire logic store_upset_in, // Flips one stored bit, as a memory fault.
	output logic miso_out, // Link data out.
	output logic err_out, // Error pin, high while any flag is set.
	output logic config_store_busy_out, // High while a store or restore runs.
	output logic settle_done_flag_out, // Data-valid pin.
	output logic [1:0] power_mode_out, // Selected power mode.
	output logic [7:0] trim_x_amount_out, // Bias reduction applied to X.
	output logic [7:0] trim_y_amount_out // Bias reduction applied to Y.
);
	// Power-up settings built from the documented defaults.
	localparam logic [7:0] AC_RST = `ASCS_RST_AUTO_CYCLE;
	localparam logic [7:0] WIN_RST = `ASCS_RST_WINDOW;
	localparam ascs_cfg_t CFG_RST = '{
		angle_zero_offset: 16'h0000,
		bias_trim_amount: 8'h00,
		trim_y_enable: 1'b0,
		trim_x_enable: 1'b0,
		direction_select: 1'b0,
		auto_cycle_source_select: AC_RST[`ASCS_BIT_SRC_SEL],
		auto_cycle_mode: AC_RST[`ASCS_BIT_CYCLE_MODE],
		auto_active_time: AC_RST[`ASCS_BIT_AUTO_ACTIVE],
		averaging_window_size: WIN_RST[7:4]
	};
	localparam logic [11:0] BUSY_CYCLES = 12'(`ASCS_STORE_BUSY_CYCLES);
	localparam logic [15:0] US_LAST = 16'(US_CYCLES - 1);

	// CRC over the stored settings, used at store and at restore.
	function automatic logic [7:0] ascs_crc8(input ascs_cfg_t d);
		logic [7:0] c;
		logic [33:0] v;
		logic fb;
		c = 8'h00;
		v = d;
		for (int i = 33; i >= 0; i--) begin
			fb = c[7] ^ v[i];
			c = {c[6:0], 1'b0} ^ (fb ? `ASCS_CRC_POLY : 8'h00);
		end
		return c;
	endfunction

	// Window code capped at the largest distinct filter setting.
	function automatic logic [3:0] ascs_win(input logic [3:0] w);
		return (w > `ASCS_WIN_MAX) ? `ASCS_WIN_MAX : w;
	endfunction

	// Register read decode, used for read and write echoes.
	function automatic logic [7:0] ascs_reg(input ascs_cfg_t c, input logic [4:0] a, input logic [2:0] e);
		logic [7:0] r;
		r = 8'h00;
		case (a)
			`ASCS_ADDR_ZERO_LO: begin
				r = c.angle_zero_offset[7:0];
			end
			`ASCS_ADDR_ZERO_HI: begin
				r = c.angle_zero_offset[15:8];
			end
			`ASCS_ADDR_BIAS_TRIM: begin
				r = c.bias_trim_amount;
			end
			`ASCS_ADDR_TRIM_AXES: begin
				r = {6'h00, c.trim_y_enable, c.trim_x_enable};
			end
			`ASCS_ADDR_DIRECTION: begin
				r[`ASCS_BIT_DIRECTION] = c.direction_select;
			end
			`ASCS_ADDR_AUTO_CYCLE: begin
				r = {c.auto_cycle_source_select, c.auto_cycle_mode, c.auto_active_time, 5'h00};
			end
			`ASCS_ADDR_WINDOW: begin
				r = {c.averaging_window_size, 4'h0};
			end
			`ASCS_ADDR_STATUS: begin
				r = {4'h0, e, 1'b0};
			end
			default: begin
				r = 8'h00;
			end
		endcase
		return r;
	endfunction

	localparam logic [7:0] CRC_RST = ascs_crc8(CFG_RST);

	ascs_core_t st;
	ascs_core_t nx;
	logic [2:0] pins;
	logic cs_now;
	logic [16:0] rx_word;
	logic [4:0] rx_count;
	logic link_tag;
	logic done;
	logic good_len;
	logic [15:0] word;
	logic [7:0] wdata;
	logic set_par;
	logic set_mem;
	logic set_crc;
	logic clr;
	logic src_ctl;
	logic tick;
	logic [3:0] win;
	logic [15:0] sensed;
	logic [15:0] target;
	logic [15:0] diff;
	logic [27:0] step;

	// Pins from outside the core clock domain.
	ascs_sync3 #(
		.W(3),
		.RESET_VAL(3'h1)
	) u_pins (
		.clk_in(clk_in),
		.reset_in(reset_in),
		.d_in({auto_cycle_pin_in, full_power_in, cs_n_in}),
		.q_out(pins)
	);

	// Link front end on the link clock.
	ascs_spi_link u_link (
		.sclk_in(sclk_in),
		.reset_in(reset_in),
		.mosi_in(mosi_in),
		.tx_word_in(st.tx),
		.frame_tag_in(st.tag),
		.miso_out(miso_out),
		.rx_word_out(rx_word),
		.rx_count_out(rx_count),
		.tag_out(link_tag)
	);

	// Next-state logic of the whole core.
	always_comb begin
		nx = st;
		set_par = 1'b0;
		set_mem = 1'b0;
		set_crc = 1'b0;
		clr = 1'b0;
		cs_now = pins[0];
		nx.cs_q = cs_now;
		// A frame ended if chip select rose and the link took the current tag.
		done = cs_now & ~st.cs_q & (link_tag == st.tag);
		good_len = (rx_count == `ASCS_FRAME_BITS) || (rx_count == `ASCS_PARITY_FRAME_BITS);
		word = (rx_count == `ASCS_PARITY_FRAME_BITS) ? rx_word[16:1] : rx_word[15:0];
		wdata = word[7:0];
		if (st.busy_cnt != 12'h000) begin
			nx.busy_cnt = 12'(st.busy_cnt - 12'h001);
		end
		// Decode the command of a finished frame.
		if (done) begin
			nx.tag = ~st.tag;
			nx.echo = 1'b0;
			if (good_len) begin
				case (word[15:13])
					`ASCS_CMD_WRITE: begin
						if (st.busy) begin
							set_mem = 1'b1;
						end else if (rx_count == `ASCS_PARITY_FRAME_BITS && (^rx_word)) begin
							set_par = 1'b1;
						end else begin
							case (word[12:8])
								`ASCS_ADDR_ZERO_LO: begin
									nx.cfg.angle_zero_offset[7:0] = wdata;
								end
								`ASCS_ADDR_ZERO_HI: begin
									nx.cfg.angle_zero_offset[15:8] = wdata;
								end
								`ASCS_ADDR_BIAS_TRIM: begin
									nx.cfg.bias_trim_amount = wdata;
								end
								`ASCS_ADDR_TRIM_AXES: begin
									nx.cfg.trim_y_enable = wdata[1];
									nx.cfg.trim_x_enable = wdata[0];
								end
								`ASCS_ADDR_DIRECTION: begin
									nx.cfg.direction_select = wdata[`ASCS_BIT_DIRECTION];
								end
								`ASCS_ADDR_AUTO_CYCLE: begin
									nx.cfg.auto_cycle_source_select = wdata[`ASCS_BIT_SRC_SEL];
									nx.cfg.auto_cycle_mode = wdata[`ASCS_BIT_CYCLE_MODE];
									nx.cfg.auto_active_time = wdata[`ASCS_BIT_AUTO_ACTIVE];
								end
								`ASCS_ADDR_WINDOW: begin
									nx.cfg.averaging_window_size = wdata[7:4];
								end
								default: begin
								end
							endcase
						end
						nx.tx = {ascs_reg(nx.cfg, word[12:8], {st.parity_error_flag,
							st.write_during_store_error, st.restore_crc_error}), 8'h00};
						nx.echo = 1'b1;
					end
					`ASCS_CMD_READ: begin
						nx.tx = {ascs_reg(st.cfg, word[12:8], {st.parity_error_flag,
							st.write_during_store_error, st.restore_crc_error}), 8'h00};
						nx.echo = 1'b1;
					end
					`ASCS_CMD_STORE: begin
						if (!st.busy) begin
							nx.saved = st.cfg;
							nx.saved_crc = ascs_crc8(st.cfg);
							nx.busy_cnt = BUSY_CYCLES;
						end
					end
					`ASCS_CMD_RESTORE: begin
						if (!st.busy) begin
							nx.cfg = st.saved;
							set_crc = (ascs_crc8(st.saved) != st.saved_crc);
							nx.busy_cnt = BUSY_CYCLES;
						end
					end
					`ASCS_CMD_CLEAR: begin
						clr = 1'b1;
					end
					default: begin
					end
				endcase
			end
		end
		// A fault in the stored copy shows up at the next restore.
		if (store_upset_in) begin
			nx.saved.angle_zero_offset[0] = ~nx.saved.angle_zero_offset[0];
		end
		nx.busy = (nx.busy_cnt != 12'h000);
		nx.parity_error_flag = (st.parity_error_flag & ~clr) | set_par;
		nx.write_during_store_error = (st.write_during_store_error & ~clr) | set_mem;
		nx.restore_crc_error = (st.restore_crc_error & ~clr) | set_crc;
		nx.err = nx.parity_error_flag | nx.write_during_store_error | nx.restore_crc_error;
		src_ctl = st.cfg.auto_cycle_source_select ? st.cfg.auto_cycle_mode : pins[2];
		if (pins[1]) begin
			nx.mode = PM_ACTIVE;
		end else if (src_ctl) begin
			nx.mode = PM_AUTO;
		end else begin
			nx.mode = PM_IDLE;
		end
		// Microsecond tick.
		tick = (st.us_cnt == 16'h0000);
		nx.us_cnt = tick ? US_LAST : 16'(st.us_cnt - 16'h0001);
		win = ascs_win(st.cfg.averaging_window_size);
		if (nx.mode != st.mode) begin
			nx.settle_done_flag = 1'b0;
			nx.us_cnt = US_LAST;
			nx.settle_us = 13'((14'h0002 << win) - 14'h0001);
		end else if (st.mode != PM_IDLE && !st.settle_done_flag && tick) begin
			if (st.settle_us <= 13'h0001) begin
				nx.settle_done_flag = 1'b1;
			end else begin
				nx.settle_us = 13'(st.settle_us - 13'h0001);
			end
		end
		sensed = st.cfg.direction_select ? 16'(16'h0000 - raw_angle_in) : raw_angle_in;
		// subtract zero offset; code is turn fraction; wraps
		target = 16'(sensed - st.cfg.angle_zero_offset);
		diff = 16'(target - st.filt[27:12]);
		step = 28'($signed({diff, 12'h000}) >>> win);
		if (st.mode != PM_IDLE && tick) begin
			nx.filt = 28'(st.filt + step);
			nx.dly = {st.dly[1], st.dly[0], st.filt[27:12]};
		end
		// Refresh the outgoing angle only while no frame runs.
		if (cs_now && st.cs_q && !st.echo && !done) begin
			nx.tx = st.dly[2];
		end
		nx.trim_x = nx.cfg.trim_x_enable ? nx.cfg.bias_trim_amount : 8'h00;
		nx.trim_y = nx.cfg.trim_y_enable ? nx.cfg.bias_trim_amount : 8'h00;
	end

	// State register.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			st <= '0;
			st.cfg <= CFG_RST;
			st.saved <= CFG_RST;
			st.saved_crc <= CRC_RST;
			st.mode <= PM_IDLE;
			st.us_cnt <= US_LAST;
			st.tag <= 1'b1;
			st.cs_q <= 1'b1;
		end else begin
			st <= nx;
		end
	end

	// Outputs come straight from the state register.
	assign err_out = st.err;
	assign config_store_busy_out = st.busy;
	assign settle_done_flag_out = st.settle_done_flag;
	assign power_mode_out = st.mode;
	assign trim_x_amount_out = st.trim_x;
	assign trim_y_amount_out = st.trim_y;
endmodule
`default_nettype wire

// file: common/ascs_cfg.svh
// Constants of the angle sensor configuration and status block.
`ifndef ASCS_CFG_SVH
`define ASCS_CFG_SVH
`define ASCS_CLK_PERIOD_PS 5000
`define ASCS_PS_PER_US 1000000
`define ASCS_CYCLES_PER_US (`ASCS_PS_PER_US / `ASCS_CLK_PERIOD_PS)
`define ASCS_STORE_BUSY_US 20
`define ASCS_STORE_BUSY_CYCLES (`ASCS_STORE_BUSY_US * `ASCS_CYCLES_PER_US)
`define ASCS_OUT_DELAY_US 3
`define ASCS_WIN_MAX 4'hc
`define ASCS_FRAME_BITS 5'h10
`define ASCS_PARITY_FRAME_BITS 5'h11
`define ASCS_CMD_CLEAR 3'h1
`define ASCS_CMD_READ 3'h2
`define ASCS_CMD_WRITE 3'h4
`define ASCS_CMD_RESTORE 3'h5
`define ASCS_CMD_STORE 3'h6
`define ASCS_ADDR_ZERO_LO 5'h00
`define ASCS_ADDR_ZERO_HI 5'h01
`define ASCS_ADDR_BIAS_TRIM 5'h02
`define ASCS_ADDR_TRIM_AXES 5'h03
`define ASCS_ADDR_DIRECTION 5'h09
`define ASCS_ADDR_AUTO_CYCLE 5'h0b
`define ASCS_ADDR_WINDOW 5'h0e
`define ASCS_ADDR_STATUS 5'h1a
`define ASCS_BIT_DIRECTION 7
`define ASCS_BIT_SRC_SEL 7
`define ASCS_BIT_CYCLE_MODE 6
`define ASCS_BIT_AUTO_ACTIVE 5
`define ASCS_WIN_LSB 4
`define ASCS_BIT_PARITY_ERR 3
`define ASCS_BIT_STORE_ERR 2
`define ASCS_BIT_CRC_ERR 1
`define ASCS_RST_AUTO_CYCLE 8'he0
`define ASCS_RST_WINDOW 8'h90
`define ASCS_CRC_POLY 8'h07
`endif

// file: common/ascs_pkg.sv
// Types shared by the angle sensor configuration and status block.
`default_nettype none
package ascs_pkg;
	// Settings that software writes and the store keeps.
	typedef struct packed {
		logic [15:0] angle_zero_offset;
		logic [7:0] bias_trim_amount;
		logic trim_y_enable;
		logic trim_x_enable;
		logic direction_select;
		logic auto_cycle_source_select;
		logic auto_cycle_mode;
		logic auto_active_time;
		logic [3:0] averaging_window_size;
	} ascs_cfg_t;
	typedef enum logic [1:0] {PM_IDLE, PM_AUTO, PM_ACTIVE} ascs_mode_t;
	// State of the serial link front end.
	typedef struct packed {
		logic tag;
		logic [4:0] count;
		logic [16:0] shift;
		logic miso;
	} ascs_link_t;
	// State of the core.
	typedef struct packed {
		ascs_cfg_t cfg;
		ascs_cfg_t saved;
		logic [7:0] saved_crc;
		logic parity_error_flag;
		logic write_during_store_error;
		logic restore_crc_error;
		logic err;
		logic [11:0] busy_cnt;
		logic busy;
		ascs_mode_t mode;
		logic settle_done_flag;
		logic [12:0] settle_us;
		logic [15:0] us_cnt;
		logic [27:0] filt;
		logic [2:0][15:0] dly;
		logic [15:0] tx;
		logic echo;
		logic tag;
		logic cs_q;
		logic [7:0] trim_x;
		logic [7:0] trim_y;
	} ascs_core_t;
endpackage
`default_nettype wire

// file: hdl/ascs_sync3.sv
// Three-flop synchroniser that accepts a change once the last two stages agree.
`default_nettype none
module ascs_sync3 #(
	parameter int W = 3,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic clk_in, // Core clock.
	input wire logic reset_in, // Asynchronous reset, active high.
	input wire logic [W-1:0] d_in, // Asynchronous inputs.
	output logic [W-1:0] q_out // Filtered synchronous copy.
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} ascs_sync_t;
	ascs_sync_t st;
	ascs_sync_t nx;
	logic [W-1:0] agree;

	// Shift the chain and take bits on which stages two and three agree.
	always_comb begin
		nx = st;
		nx.s1 = d_in;
		nx.s2 = st.s1;
		nx.s3 = st.s2;
		agree = ~(st.s2 ^ st.s3);
		nx.q = (st.s3 & agree) | (st.q & ~agree);
	end

	// State register.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			st <= {RESET_VAL, RESET_VAL, RESET_VAL, RESET_VAL};
		end else begin
			st <= nx;
		end
	end

	assign q_out = st.q;
endmodule
`default_nettype wire

// file: hdl/ascs_spi_link.sv
// Serial link front end that runs on the link clock.
`default_nettype none
`include "ascs_cfg.svh"
module ascs_spi_link
	import ascs_pkg::*;
(
	input wire logic sclk_in, // Link clock, idle low.
	input wire logic reset_in, // Asynchronous reset, active high.
	input wire logic mosi_in, // Serial data from the controller.
	input wire logic [15:0] tx_word_in, // Word to send, steady while a frame runs.
	input wire logic frame_tag_in, // Tag that marks the next frame as new.
	output logic miso_out, // Serial data to the controller.
	output logic [16:0] rx_word_out, // Bits taken in, newest in bit 0.
	output logic [4:0] rx_count_out, // Bits taken in this frame.
	output logic tag_out // Tag of the last frame seen.
);
	ascs_link_t st;
	ascs_link_t nx;
	logic first;

	// A tag that differs from the held one marks the first edge of a frame.
	always_comb begin
		nx = st;
		first = (st.tag != frame_tag_in);
		if (first) begin
			nx.tag = frame_tag_in;
			nx.count = 5'h01;
			nx.shift = {16'h0000, mosi_in};
			nx.miso = tx_word_in[15];
		end else begin
			nx.count = (st.count == 5'h1f) ? st.count : 5'(st.count + 5'h01);
			nx.shift = {st.shift[15:0], mosi_in};
			nx.miso = (st.count < `ASCS_FRAME_BITS) ? tx_word_in[4'(4'hf - st.count[3:0])] : 1'b0;
		end
	end

	// State register, rising edge of the link clock.
	always_ff @(posedge sclk_in or posedge reset_in) begin
		if (reset_in) begin
			st <= '0;
		end else begin
			st <= nx;
		end
	end

	assign miso_out = st.miso;
	assign rx_word_out = st.shift;
	assign rx_count_out = st.count;
	assign tag_out = st.tag;
endmodule
`default_nettype wire

// file: tb/ascs_core_checker.sv
// Assertion checker of the angle sensor configuration and status block.
`default_nettype none
`include "ascs_cfg.svh"
module ascs_core_checker #(
	parameter int US_CYCLES = 200
) (
	input wire logic clk_in, // Core clock.
	input wire logic reset_in, // Asynchronous reset.
	input wire logic cs_n_in, // Chip select.
	input wire logic full_power_in, // Full-power pin.
	input wire logic err_out, // Error pin.
	input wire logic config_store_busy_out, // Store busy.
	input wire logic settle_done_flag_out, // Data valid.
	input wire logic [1:0] power_mode_out, // Power mode.
	input wire logic [7:0] trim_x_amount_out, // X trim.
	input wire logic [7:0] trim_y_amount_out // Y trim.
);
	timeunit 1ns;
	timeprecision 100ps;
	// The store busy time is a fixed cycle count in the core, whatever the tick rate.
	localparam int BUSY = `ASCS_STORE_BUSY_CYCLES;
	logic [15:0] bcnt;
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	// Counts how long the store has been busy.
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) bcnt <= 16'h0;
		else bcnt <= config_store_busy_out ? bcnt + 16'h1 : 16'h0;
	end
	a_err_reset: assert property ($fell(reset_in) |-> !err_out)
		else $error("Error pin high after reset.");
	a_mode_active: assert property (full_power_in [*8] |-> power_mode_out == 2'h2)
		else $error("Full power did not force active.");
	a_mode_notact: assert property (!full_power_in [*8] |-> power_mode_out != 2'h2)
		else $error("Active mode without full power.");
	a_idle_dv: assert property (power_mode_out == 2'h0 [*2] |-> !settle_done_flag_out)
		else $error("Data valid high in idle.");
	a_dv_drop: assert property ($changed(power_mode_out) && power_mode_out != 2'h0
		|-> ##[0:1] !settle_done_flag_out)
		else $error("Data valid not dropped on mode entry.");
	a_dv_rise: assert property ($rose(settle_done_flag_out)
		|-> power_mode_out != 2'h0 && $past(power_mode_out) != 2'h0)
		else $error("Data valid rose without settling.");
	a_err_clear: assert property ($fell(err_out) |-> cs_n_in && $past(cs_n_in, 3))
		else $error("Error pin fell outside a clear.");
	a_busy_len: assert property ($fell(config_store_busy_out)
		|-> bcnt >= BUSY - US_CYCLES && bcnt <= BUSY + 1)
		else $error("Store busy length wrong.");
	a_trim_stable: assert property ((!cs_n_in && !config_store_busy_out) [*8]
		|=> $stable(trim_x_amount_out) && $stable(trim_y_amount_out))
		else $error("Trim changed without a command.");
	c_err: cover property ($rose(err_out));
	c_busy: cover property ($fell(config_store_busy_out));
	c_dv: cover property ($rose(settle_done_flag_out) && power_mode_out == 2'h2);
endmodule
bind ascs_core ascs_core_checker #(.US_CYCLES(US_CYCLES)) i_ascs_core_checker (.clk_in(clk_in),
	.reset_in(reset_in), .cs_n_in(cs_n_in), .full_power_in(full_power_in), .err_out(err_out),
	.config_store_busy_out(config_store_busy_out), .settle_done_flag_out(settle_done_flag_out),
	.power_mode_out(power_mode_out), .trim_x_amount_out(trim_x_amount_out),
	.trim_y_amount_out(trim_y_amount_out));
`default_nettype wire

// file: tb/ascs_host.sv
// Behavioural host controller that drives the sensor's serial link.
`default_nettype none
module ascs_host (
	output logic sclk_out, // Link clock, idle low.
	output logic cs_n_out, // Chip select, active low.
	output logic mosi_out, // Serial data to the sensor.
	input wire logic miso_in, // Serial data from the sensor.
	output logic [15:0] rx_out, // Word read in the last frame.
	output logic done_out // Pulse when a frame ends.
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle levels at time zero.
	initial begin
		sclk_out = 1'b0;
		cs_n_out = 1'b1;
		mosi_out = 1'b0;
		rx_out = 16'h0;
		done_out = 1'b0;
	end
	// Sends one frame MSB first; the clock runs only inside the frame.
	task automatic frame(input logic [15:0] w, input logic p17, input logic par);
		int i;
		cs_n_out = 1'b0;
		#43;
		for (i = 0; i < 16 + int'(p17); i++) begin
			mosi_out = (i < 16) ? w[15 - i] : par;
			#15 sclk_out = 1'b1;
			#15 sclk_out = 1'b0;
			if (i < 16) rx_out[15 - i] = miso_in;
		end
		#15 cs_n_out = 1'b1;
		// A released data line must not keep showing the last bit.
		mosi_out = ~mosi_out;
		#65 done_out = 1'b1;
		#5 done_out = 1'b0;
	endtask
endmodule
`default_nettype wire

// file: tb/tb_ascs_core.sv
// Self-checking testbench of the angle sensor configuration and status block.
`default_nettype none
`include "ascs_cfg.svh"
module tb_ascs_core;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int US = 8;
	localparam logic [2:0] WR = `ASCS_CMD_WRITE;
	localparam logic [2:0] RD = `ASCS_CMD_READ;
	localparam logic [2:0] CL = `ASCS_CMD_CLEAR;
	localparam logic [2:0] RS = `ASCS_CMD_RESTORE;
	localparam logic [2:0] ST = `ASCS_CMD_STORE;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic full_power_in = 1'b0;
	logic auto_cycle_pin_in = 1'b0;
	logic store_upset_in = 1'b0;
	logic [15:0] raw_angle_in = 16'h0;
	logic sclk_in, cs_n_in, mosi_in, miso_out, err_out, busy, dv, done;
	logic [1:0] mode;
	logic [7:0] tx8, ty8, t, lo, hi;
	logic [15:0] rx;
	logic [16:0] q[$];
	logic [16:0] e;
	logic [16:0] nxt = 17'h0;
	logic [4:0] ra[9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h09, 5'h0b, 5'h0e, 5'h1a, 5'h1f};
	logic [7:0] rv[9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0, 8'h90, 8'h00, 8'h00};
	logic [3:0] wl[3] = '{4'hd, 4'h3, 4'h0};
	int err_count = 0;
	int compares = 0;
	int seed = 47;
	int n, k, s;
	ascs_core #(.US_CYCLES(US)) i_ascs_core (.clk_in(clk_in), .reset_in(reset_in), .sclk_in(sclk_in),
		.cs_n_in(cs_n_in), .mosi_in(mosi_in), .full_power_in(full_power_in),
		.auto_cycle_pin_in(auto_cycle_pin_in), .raw_angle_in(raw_angle_in), .store_upset_in(store_upset_in),
		.miso_out(miso_out), .err_out(err_out), .config_store_busy_out(busy), .settle_done_flag_out(dv),
		.power_mode_out(mode), .trim_x_amount_out(tx8), .trim_y_amount_out(ty8));
	ascs_host i_ascs_host (.sclk_out(sclk_in), .cs_n_out(cs_n_in), .mosi_out(mosi_in), .miso_in(miso_out),
		.rx_out(rx), .done_out(done));
	// Core clock.
	initial forever #2.5 clk_in = ~clk_in;
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("Mismatches %0d, comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge clk_in);
		#1;
	endtask
	// Sends a frame; the reply of the next frame carries this one's register value.
	task automatic frm(input logic [2:0] c, input logic [4:0] a, input logic [7:0] d, input logic [7:0] ev,
		input logic p17 = 1'b0, input logic bad = 1'b0);
		cyc(1);
		q.push_back(nxt);
		i_ascs_host.frame({c, a, d}, p17, ^{c, a, d, bad});
		nxt = (c == RD || c == WR) ? {1'b1, ev, 8'h00} : 17'h0;
		// Realign to the core clock so that pin changes after a frame land just past an edge.
		cyc(1);
	endtask
	task automatic wait_busy;
		int m;
		m = 0;
		while (busy !== 1'b0 && m < 5000) begin
			cyc(1);
			m++;
		end
		chk(16'(m < 5000), 16'h1);
	endtask
	// Compares each frame's reply with the oldest expectation.
	always @(posedge done) begin
		e = q.pop_front();
		if (e[16] === 1'b1) chk(rx, e[15:0]);
	end
	// Cuts a hung run short.
	initial begin
		#490000;
		err_count++;
		final_report;
	end
	// Main sequence.
	initial begin
		repeat (3) @(posedge clk_in);
		#1 reset_in = 1'b0;
		cyc(8);
		chk(16'(mode), 16'h1);
		for (k = 0; k < 9; k++) frm(RD, ra[k], 8'h00, rv[k]);
		lo = 8'($random(seed));
		hi = 8'($random(seed));
		t = 8'($random(seed));
		frm(WR, 5'h00, lo, lo);
		frm(WR, 5'h01, hi, hi);
		frm(RD, 5'h00, 8'h00, lo);
		frm(WR, 5'h02, t, t);
		for (k = 0; k < 4; k++) begin
			frm(WR, 5'h03, 8'(k), 8'(k));
			cyc(10);
			chk(16'(tx8), k[0] ? 16'(t) : 16'h0);
			chk(16'(ty8), k[1] ? 16'(t) : 16'h0);
		end
		frm(WR, 5'h09, 8'h80, 8'h80);
		frm(WR, 5'h1a, 8'hff, 8'h00);
		frm(WR, 5'h02, 8'h55, 8'h55, 1'b1);
		frm(WR, 5'h02, 8'haa, 8'h55, 1'b1, 1'b1);
		chk(16'(err_out), 16'h1);
		frm(RD, 5'h02, 8'h00, 8'h55, 1'b1, 1'b1);
		frm(RD, 5'h1a, 8'h00, 8'h08);
		frm(CL, 5'h00, 8'h00, 8'h00);
		cyc(10);
		chk(16'(err_out), 16'h0);
		frm(ST, 5'h00, 8'h00, 8'h00);
		chk(16'(busy), 16'h1);
		frm(WR, 5'h02, 8'h11, 8'h55);
		wait_busy;
		frm(RD, 5'h1a, 8'h00, 8'h04);
		frm(CL, 5'h00, 8'h00, 8'h00);
		frm(RS, 5'h00, 8'h00, 8'h00);
		wait_busy;
		frm(RD, 5'h1a, 8'h00, 8'h00);
		store_upset_in = 1'b1;
		cyc(1);
		store_upset_in = 1'b0;
		frm(RS, 5'h00, 8'h00, 8'h00);
		wait_busy;
		chk(16'(err_out), 16'h1);
		frm(RD, 5'h1a, 8'h00, 8'h02);
		frm(CL, 5'h00, 8'h00, 8'h00);
		for (k = 0; k < 16; k++) begin
			frm(WR, 5'h0b, {k[1], k[0], 6'h20}, {k[1], k[0], 6'h20});
			full_power_in = k[3];
			auto_cycle_pin_in = k[2];
			cyc(10);
			chk(16'(mode), k[3] ? 16'h2 : 16'(k[1] ? k[0] : k[2]));
		end
		full_power_in = 1'b0;
		frm(WR, 5'h0b, 8'ha0, 8'ha0);
		for (k = 0; k < 3; k++) begin
			frm(WR, 5'h0e, {wl[k], 4'h0}, {wl[k], 4'h0});
			cyc(10);
			chk(16'(dv), 16'h0);
			full_power_in = 1'b1;
			n = 0;
			while (dv !== 1'b1 && n < 70000) begin
				cyc(1);
				n++;
			end
			s = ((2 << (wl[k] > 4'hc ? 12 : int'(wl[k]))) - 1) * US;
			chk(16'(n >= s - US && n <= s + US + 8), 16'h1);
			full_power_in = 1'b0;
		end
		frm(WR, 5'h00, 8'h20, 8'h20);
		frm(WR, 5'h01, 8'h00, 8'h00);
		frm(WR, 5'h09, 8'h00, 8'h00);
		raw_angle_in = 16'h0010;
		full_power_in = 1'b1;
		cyc(100);
		frm(CL, 5'h00, 8'h00, 8'h00);
		nxt = 17'h1fff0;
		frm(RD, 5'h1a, 8'h00, 8'h00);
		// Reversed direction: the angle becomes minus raw minus offset.
		frm(WR, 5'h09, 8'h80, 8'h80);
		frm(CL, 5'h00, 8'h00, 8'h00);
		nxt = 17'h1ffd0;
		frm(RD, 5'h1a, 8'h00, 8'h00);
		frm(CL, 5'h00, 8'h00, 8'h00);
		final_report;
	end
endmodule
`default_nettype wire
